// *** include/hspw_pkg.sv ***
// package of constants and types for the high-speed pwm generator
// ----------------------------------------------------------------
// Behaviour
// RL1 - buffered duty/dead time applied next period
// RL2 - immediate update applies within running period
// RL3 - pin owner bit: 0 gpio, 1 pwm
// RL4 - override enables at io control bits 9, 8
// RL5 - overridden output driven from override value
// RL6 - mode 00 complementary, 01 redundant, 10 push-pull
// RL7 - control bit 8 picks master duty register
// RL8 - immediate duty crossing switches now, dead time kept
// RL9 - current limit forces levels fast, dead time kept
// RL10 - rollover duty write never gives full duty
// RL11 - rollover dead-time write never shortens pulse
// RL12 - zero duty in redundant/push-pull gives no glitch
// RL13 - override before enable holds, any divider
// RL14 - software follows glitch-free enable order
// RL15 - control bit 9 low selects master time base
// RL16 - global control bit 15 enables all counting
// RL17 - complementary low inverts high with dead time
// RL18 - period boundary is counter rollover to zero
// ----------------------------------------------------------------
package hspw_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CLOCK_DIV = 8'h04;
	localparam logic [7:0] ADDR_MASTER_PERIOD = 8'h08;
	localparam logic [7:0] ADDR_MASTER_DUTY = 8'h0C;
	localparam logic [7:0] ADDR_GEN_CTRL = 8'h10;
	localparam logic [7:0] ADDR_GEN_IO_CTRL = 8'h14;
	localparam logic [7:0] ADDR_GEN_DUTY = 8'h18;
	localparam logic [7:0] ADDR_DEAD_TIME = 8'h1C;
	localparam logic [7:0] ADDR_GEN_PERIOD = 8'h20;
	localparam logic [7:0] ADDR_LIMIT_CTRL = 8'h24;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h28;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h2C;
	localparam logic [7:0] ADDR_STATE = 8'h30;
	// field positions
	localparam int GLOBAL_EN_BIT = 15;
	localparam int IMM_UPDATE_BIT = 0;
	localparam int DUTY_SRC_BIT = 8;
	localparam int TB_SEL_BIT = 9;
	localparam int HIGH_OWNER_BIT = 15;
	localparam int LOW_OWNER_BIT = 14;
	localparam int MODE_LSB = 10;
	localparam int HIGH_OVR_BIT = 9;
	localparam int LOW_OVR_BIT = 8;
	localparam int OVR_VALUE_LSB = 6;
	localparam int LIMIT_EN_BIT = 0;
	localparam int LIMIT_HIGH_BIT = 1;
	localparam int LIMIT_LOW_BIT = 2;
	// interrupt status bits
	localparam int IRQ_PERIOD_BIT = 0;
	localparam int IRQ_LIMIT_BIT = 1;
	localparam int IRQ_BITS = 2;
	// reset values
	localparam logic [15:0] PERIOD_RESET = 16'h0063;
	localparam logic [15:0] DUTY_RESET = 16'h0000;
	localparam logic [15:0] DEAD_RESET = 16'h0000;
	localparam logic [15:0] IO_CTRL_RESET = 16'h0000;
	// synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 3;
	// output modes
	typedef enum logic [1:0] {
		HSPW_MODE_COMP = 2'b00,
		HSPW_MODE_REDUNDANT = 2'b01,
		HSPW_MODE_PUSHPULL = 2'b10,
		HSPW_MODE_INDEP = 2'b11
	} hspw_mode_e;
	// ahb data-phase state
	typedef enum logic [1:0] {
		HSPW_BUS_IDLE = 2'b00,
		HSPW_BUS_WRITE = 2'b01,
		HSPW_BUS_READ = 2'b10
	} hspw_bus_e;
endpackage : hspw_pkg

// *** rtl/hspw_deadtime.sv ***
// dead-time inserter: delays each rising edge of both complementary legs
`timescale 1ns/100ps
module hspw_deadtime #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// tick and settings
	input wire logic tick,
	input wire logic [W-1:0] deadTime,
	// raw high leg and shaped outputs
	input wire logic rawHigh,
	output logic outHigh,
	output logic outLow
);
	import hspw_pkg::*;
	// ----------------------------------------------------------------
	// edge delay
	// ----------------------------------------------------------------
	logic lastRaw; // raw level already being followed
	logic [W-1:0] waitCnt; // ticks left before the new leg turns on
	// on a raw change both legs go off first; the new leg waits deadTime
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lastRaw <= 1'b0;
			waitCnt <= '0;
			outHigh <= 1'b0;
			outLow <= 1'b0;
		end else if (rawHigh != lastRaw) begin
			// both off at once, even mid-gap: no overlap ever RL17 RL8
			lastRaw <= rawHigh;
			waitCnt <= deadTime;
			outHigh <= 1'b0;
			outLow <= 1'b0;
			if (deadTime == '0) begin
				outHigh <= rawHigh;
				outLow <= ~rawHigh;
			end
		end else if (waitCnt != '0) begin
			// gap still running
			if (tick) begin
				waitCnt <= waitCnt - 1'b1;
				if (waitCnt == W'(1)) begin
					outHigh <= lastRaw;
					outLow <= ~lastRaw;
				end
			end
		end else begin
			outHigh <= lastRaw; // RL17
			outLow <= ~lastRaw;
		end
	end
	// complementary legs never on together RL17
	a_no_overlap: assert property (@(posedge clk) disable iff (sys_rst)
		!(outHigh && outLow)) else $error("both legs active"); // RL17
endmodule : hspw_deadtime

// *** rtl/hspw_gen.sv ***
// high-speed pwm generator with ahb-lite registers, override and current limit
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
module hspw_gen #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// current-limit pin
	input wire logic currentLimit,
	// gpio data for pins not owned by the generator
	input wire logic gpioHigh,
	input wire logic gpioLow,
	// output pins
	output logic highSideOutput,
	output logic lowSideOutput,
	// interrupt
	output logic irq
);
	import hspw_pkg::*;
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [15:0] pwmGlobalCtrl; // module-wide control
	logic [3:0] pwmClockDivider; // divide by 2^n
	logic [W-1:0] masterPeriod; // shared time base period
	logic [W-1:0] masterDuty; // shared duty
	logic [15:0] generatorCtrl; // generator control
	logic [15:0] generatorIoCtrl; // pin ownership, mode, override
	logic [W-1:0] generatorDuty; // own duty
	logic [W-1:0] deadTimeValue; // dead time in ticks
	logic [W-1:0] genPeriod; // independent period
	logic [2:0] limitCtrl; // enable, forced high, forced low
	logic [IRQ_BITS-1:0] irqStatus; // sticky events
	logic [IRQ_BITS-1:0] irqMask; // unmask bits
	// bus data-phase tracking
	hspw_bus_e busState;
	logic [7:0] busAddr;
	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	logic addrPhase;
	assign addrPhase = hsel && hready && htrans[1];
	assign hreadyout = 1'b1; // zero wait states
	assign hresp = 1'b0; // always okay
	// capture the address phase
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busState <= HSPW_BUS_IDLE;
			busAddr <= 8'h00;
		end else if (hready) begin
			busAddr <= haddr;
			if (!addrPhase) begin
				busState <= HSPW_BUS_IDLE;
			end else if (hwrite) begin
				busState <= HSPW_BUS_WRITE;
			end else begin
				busState <= HSPW_BUS_READ;
			end
		end
	end
	logic wrEn;
	assign wrEn = (busState == HSPW_BUS_WRITE);
	logic rdStatus; // read of status clears it
	assign rdStatus = addrPhase && !hwrite && (haddr == ADDR_IRQ_STATUS);
	// ----------------------------------------------------------------
	// time base and clock divider
	// ----------------------------------------------------------------
	logic enabled;
	assign enabled = pwmGlobalCtrl[GLOBAL_EN_BIT]; // RL16
	logic [15:0] divCnt; // prescaler
	logic tick; // one pwm clock
	assign tick = enabled &&
		((divCnt & ((16'h0001 << pwmClockDivider) - 16'h0001)) == 16'h0000);
	// prescaler runs only while enabled
	always_ff @(posedge clk) begin
		if (sys_rst || !enabled) begin
			divCnt <= 16'h0000;
		end else begin
			divCnt <= divCnt + 16'h0001;
		end
	end
	logic [W-1:0] masterCnt; // shared counter
	logic [W-1:0] ownCnt; // independent counter
	// both counters roll from period to zero RL18
	always_ff @(posedge clk) begin
		if (sys_rst || !enabled) begin
			masterCnt <= '0;
			ownCnt <= '0;
		end else if (tick) begin
			masterCnt <= (masterCnt >= masterPeriod) ? '0 : masterCnt + 1'b1;
			ownCnt <= (ownCnt >= genPeriod) ? '0 : ownCnt + 1'b1;
		end
	end
	logic useOwn;
	assign useOwn = generatorCtrl[TB_SEL_BIT]; // RL15
	logic [W-1:0] count;
	assign count = useOwn ? ownCnt : masterCnt;
	logic boundary; // rollover cycle RL18
	assign boundary = tick && (count >= (useOwn ? genPeriod : masterPeriod));
	// ----------------------------------------------------------------
	// active duty and dead time
	// ----------------------------------------------------------------
	logic immediate;
	assign immediate = generatorCtrl[IMM_UPDATE_BIT];
	logic [W-1:0] selDuty; // RL7
	assign selDuty = generatorCtrl[DUTY_SRC_BIT] ? masterDuty : generatorDuty;
	logic [W-1:0] activeDuty;
	logic [W-1:0] activeDead;
	// registers are the buffers; copy only at rollover unless immediate or disabled.
	// the rollover copy is skipped in a cycle that holds a write, so a write that
	// lands on rollover waits a whole period and cannot corrupt this one
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			activeDuty <= DUTY_RESET;
			activeDead <= DEAD_RESET;
		end else if (immediate || !enabled) begin
			activeDuty <= selDuty; // RL2 RL8
			activeDead <= deadTimeValue; // RL2
		end else if (boundary && !wrEn) begin
			activeDuty <= selDuty; // RL1 RL10
			activeDead <= deadTimeValue; // RL1 RL11
		end
	end
	// raw waveform: high while count below duty, so zero duty is never on
	logic rawHigh;
	assign rawHigh = enabled && (count < activeDuty); // RL12 RL8
	logic dtIn; // raw leg, or the forced limit level in complementary mode
	logic dtHigh;
	logic dtLow;
	hspw_deadtime #(.W(W)) u_dead (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(tick),
		.deadTime(activeDead),
		.rawHigh(dtIn),
		.outHigh(dtHigh),
		.outLow(dtLow)
	);
	// ----------------------------------------------------------------
	// current limit
	// ----------------------------------------------------------------
	logic limitLevel;
	hspw_sync u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pinIn(currentLimit),
		.level(limitLevel)
	);
	logic limitActive;
	assign limitActive = limitCtrl[LIMIT_EN_BIT] && limitLevel;
	// ----------------------------------------------------------------
	// output mode, override and ownership
	// ----------------------------------------------------------------
	hspw_mode_e mode;
	assign mode = hspw_mode_e'(generatorIoCtrl[MODE_LSB +: 2]);
	logic ppPhase; // push-pull alternates legs each period
	always_ff @(posedge clk) begin
		if (sys_rst || !enabled) begin
			ppPhase <= 1'b0;
		end else if (boundary) begin
			ppPhase <= ~ppPhase;
		end
	end
	logic modeHigh;
	logic modeLow;
	// mode decode; in complementary mode the limit goes through dead time
	always_comb begin
		modeHigh = 1'b0;
		modeLow = 1'b0;
		case (mode)
			HSPW_MODE_COMP: begin // RL6 RL17
				modeHigh = dtHigh;
				modeLow = dtLow;
			end
			HSPW_MODE_REDUNDANT: begin // RL6
				modeHigh = rawHigh;
				modeLow = rawHigh;
			end
			HSPW_MODE_PUSHPULL: begin // RL6
				modeHigh = rawHigh && !ppPhase;
				modeLow = rawHigh && ppPhase;
			end
			default: begin
				modeHigh = rawHigh;
				modeLow = 1'b0;
			end
		endcase
		if (limitActive && mode != HSPW_MODE_COMP) begin
			modeHigh = limitCtrl[LIMIT_HIGH_BIT]; // RL9
			modeLow = limitCtrl[LIMIT_LOW_BIT];
		end
	end
	// forced complementary limit: steer dead-time unit by choosing legs
	logic compLimitHigh;
	assign compLimitHigh = limitCtrl[LIMIT_HIGH_BIT];
	// forced level enters ahead of the dead-time unit, so the gap stays RL9
	assign dtIn = (limitActive && mode == HSPW_MODE_COMP) ?
		compLimitHigh : rawHigh;
	logic pinHigh;
	logic pinLow;
	// override works whatever the enable or divider; acts on every clk
	always_comb begin
		pinHigh = modeHigh;
		pinLow = modeLow;
		if (generatorIoCtrl[HIGH_OVR_BIT]) begin
			pinHigh = generatorIoCtrl[OVR_VALUE_LSB + 1]; // RL4 RL5 RL13
		end
		if (generatorIoCtrl[LOW_OVR_BIT]) begin
			pinLow = generatorIoCtrl[OVR_VALUE_LSB]; // RL4 RL5 RL13
		end
	end
	// registered pins with ownership selection
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			highSideOutput <= 1'b0;
			lowSideOutput <= 1'b0;
		end else begin
			highSideOutput <= generatorIoCtrl[HIGH_OWNER_BIT] ?
				pinHigh : gpioHigh; // RL3
			lowSideOutput <= generatorIoCtrl[LOW_OWNER_BIT] ?
				pinLow : gpioLow; // RL3
		end
	end
	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// one write per data phase at the captured address
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pwmGlobalCtrl <= 16'h0000;
			pwmClockDivider <= 4'h0;
			masterPeriod <= PERIOD_RESET;
			masterDuty <= DUTY_RESET;
			generatorCtrl <= 16'h0000;
			generatorIoCtrl <= IO_CTRL_RESET;
			generatorDuty <= DUTY_RESET;
			deadTimeValue <= DEAD_RESET;
			genPeriod <= PERIOD_RESET;
			limitCtrl <= 3'h0;
			irqMask <= '0;
		end else if (wrEn) begin
			case (busAddr)
				ADDR_GLOBAL_CTRL: pwmGlobalCtrl <= hwdata[15:0];
				ADDR_CLOCK_DIV: pwmClockDivider <= hwdata[3:0];
				ADDR_MASTER_PERIOD: masterPeriod <= hwdata[W-1:0];
				ADDR_MASTER_DUTY: masterDuty <= hwdata[W-1:0];
				ADDR_GEN_CTRL: generatorCtrl <= hwdata[15:0];
				ADDR_GEN_IO_CTRL: generatorIoCtrl <= hwdata[15:0];
				ADDR_GEN_DUTY: generatorDuty <= hwdata[W-1:0];
				ADDR_DEAD_TIME: deadTimeValue <= hwdata[W-1:0];
				ADDR_GEN_PERIOD: genPeriod <= hwdata[W-1:0];
				ADDR_LIMIT_CTRL: limitCtrl <= hwdata[2:0];
				ADDR_IRQ_MASK: irqMask <= hwdata[IRQ_BITS-1:0];
				default: begin
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	logic limitSeen; // edge detect on the clean level
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			limitSeen <= 1'b0;
		end else begin
			limitSeen <= limitActive;
		end
	end
	logic [IRQ_BITS-1:0] events;
	assign events = {limitActive && !limitSeen, boundary};
	// read clears, a same-cycle event wins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irqStatus <= '0;
		end else begin
			irqStatus <= (rdStatus ? '0 : irqStatus) | events;
		end
	end
	assign irq = |(irqStatus & irqMask);
	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// registered read data, valid in the data phase
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hrdata <= 32'h00000000;
		end else if (addrPhase && !hwrite) begin
			case (haddr)
				ADDR_GLOBAL_CTRL: hrdata <= {16'h0000, pwmGlobalCtrl};
				ADDR_CLOCK_DIV: hrdata <= {28'h0000000, pwmClockDivider};
				ADDR_MASTER_PERIOD: hrdata <= 32'(masterPeriod);
				ADDR_MASTER_DUTY: hrdata <= 32'(masterDuty);
				ADDR_GEN_CTRL: hrdata <= {16'h0000, generatorCtrl};
				ADDR_GEN_IO_CTRL: hrdata <= {16'h0000, generatorIoCtrl};
				ADDR_GEN_DUTY: hrdata <= 32'(generatorDuty);
				ADDR_DEAD_TIME: hrdata <= 32'(deadTimeValue);
				ADDR_GEN_PERIOD: hrdata <= 32'(genPeriod);
				ADDR_LIMIT_CTRL: hrdata <= {29'h0000000, limitCtrl};
				ADDR_IRQ_STATUS: hrdata <= 32'(irqStatus);
				ADDR_IRQ_MASK: hrdata <= 32'(irqMask);
				ADDR_STATE: hrdata <= {16'h0000, 16'(count)};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_buffered_hold: assert property (@(posedge clk) disable iff (sys_rst)
		(enabled && !immediate && !boundary) |=> $stable(activeDuty))
		else $error("duty changed inside period"); // RL1
	a_immediate_load: assert property (@(posedge clk) disable iff (sys_rst)
		immediate |=> activeDuty == $past(selDuty))
		else $error("immediate duty not applied"); // RL2
	a_owner_gpio: assert property (@(posedge clk) disable iff (sys_rst)
		!generatorIoCtrl[HIGH_OWNER_BIT] |=> highSideOutput == $past(gpioHigh))
		else $error("gpio not driving high pin"); // RL3
	a_override_high: assert property (@(posedge clk) disable iff (sys_rst)
		(generatorIoCtrl[HIGH_OWNER_BIT] && generatorIoCtrl[HIGH_OVR_BIT])
		|=> highSideOutput == $past(generatorIoCtrl[OVR_VALUE_LSB + 1]))
		else $error("high override ignored"); // RL5
	a_override_low: assert property (@(posedge clk) disable iff (sys_rst)
		(generatorIoCtrl[LOW_OWNER_BIT] && generatorIoCtrl[LOW_OVR_BIT])
		|=> lowSideOutput == $past(generatorIoCtrl[OVR_VALUE_LSB]))
		else $error("low override ignored"); // RL4 RL13
	a_zero_duty: assert property (@(posedge clk) disable iff (sys_rst)
		(activeDuty == '0) |-> !rawHigh)
		else $error("pulse with zero duty"); // RL12
	a_rollover_zero: assert property (@(posedge clk) disable iff (sys_rst)
		boundary |=> ($past(useOwn) ? ownCnt : masterCnt) == '0)
		else $error("boundary without rollover"); // RL18
	a_limit_force: assert property (@(posedge clk) disable iff (sys_rst)
		(limitActive && mode == HSPW_MODE_REDUNDANT)
		|-> modeHigh == limitCtrl[LIMIT_HIGH_BIT])
		else $error("limit did not force output"); // RL9
endmodule : hspw_gen

// *** rtl/hspw_sync.sv ***
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module hspw_sync (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// raw pin and clean level
	input wire logic pinIn,
	output logic level
);
	import hspw_pkg::*;
	// ----------------------------------------------------------------
	// synchroniser chain
	// ----------------------------------------------------------------
	logic [SYNC_STAGES-1:0] stage; // stage[0] is read only by stage[1]
	// shift the pin through the chain
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stage <= '0;
		end else begin
			stage <= {stage[SYNC_STAGES-2:0], pinIn};
		end
	end
	// accept a new level only when the last two stages agree
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			level <= 1'b0;
		end else if (stage[1] == stage[2]) begin
			level <= stage[2];
		end
	end
endmodule : hspw_sync

// *** tb/hspw_gate_driver.sv ***
// gate-driver model standing on the two pwm pins
`timescale 1ns/100ps
module hspw_gate_driver (
	// clock
	input wire logic clk,
	// pwm legs from the generator
	input wire logic highSideOutput,
	input wire logic lowSideOutput,
	// bench controls
	input wire logic tripReq,
	input wire logic clrStats,
	// sensed fault and statistics
	output logic currentLimit,
	output int shootCount,
	output int longestOn
);
	int run; // cycles the high switch has been on so far
	// the sense comparator output is a plain level
	assign currentLimit = tripReq;
	// both switches on at once shorts the rail, so count every such cycle
	always @(posedge clk) begin
		if (clrStats) begin
			shootCount = 0;
			longestOn = 0;
		end else if (highSideOutput === 1'b1 && lowSideOutput === 1'b1) begin
			shootCount++;
		end
		// a stuck-on high switch shows as an over-long on time
		run = (highSideOutput === 1'b1) ? run + 1 : 0;
		if (run > longestOn) begin
			longestOn = run;
		end
	end
	// statistics start clean
	initial begin
		run = 0;
	end
endmodule : hspw_gate_driver

// *** tb/testbench.sv ***
// self-checking bench for the high-speed pwm generator
`timescale 1ns/100ps
module testbench;
	import hspw_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, irq, currentLimit;
	logic highSideOutput, lowSideOutput;
	logic gpioHigh = 1'b0, gpioLow = 1'b0, tripReq = 1'b0, clrStats = 1'b0;
	int shootCount, longestOn, nh, nl, n;
	int mismatches = 0;
	int checks_done = 0;
	logic [31:0] rd;
	// register rows: address, write flag, data, expected read
	typedef struct packed {
		logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;
	} hspw_row_s;
	hspw_row_s rows [11] = '{
		'{ADDR_GEN_PERIOD, 1'b0, 32'h0, 32'(PERIOD_RESET)},
		'{ADDR_GEN_DUTY, 1'b0, 32'h0, 32'(DUTY_RESET)},
		'{ADDR_DEAD_TIME, 1'b0, 32'h0, 32'(DEAD_RESET)},
		'{ADDR_GEN_IO_CTRL, 1'b0, 32'h0, 32'(IO_CTRL_RESET)},
		'{ADDR_STATE, 1'b0, 32'h0, 32'h0},
		'{ADDR_IRQ_MASK, 1'b0, 32'h0, 32'h0},
		'{8'h3C, 1'b1, 32'hFFFF, 32'h0},
		'{ADDR_GEN_CTRL, 1'b1, 32'h0301, 32'h0301},
		'{ADDR_MASTER_PERIOD, 1'b1, 32'h9, 32'h9},
		'{ADDR_GEN_PERIOD, 1'b1, 32'h13, 32'h13},
		'{ADDR_GEN_CTRL, 1'b1, 32'h0, 32'h0}};
	// waveform rows: ctrl, io ctrl, dead time, high and low cycles in 40
	typedef struct packed {
		logic [15:0] c; logic [15:0] io; logic [15:0] dt;
		logic [7:0] eh; logic [7:0] el;
	} hspw_wave_s;
	hspw_wave_s waves [7] = '{
		'{16'h0000, 16'hC000, 16'h0, 8'd16, 8'd24},
		'{16'h0000, 16'hC000, 16'h1, 8'd12, 8'd20},
		'{16'h0000, 16'hC400, 16'h0, 8'd16, 8'd16},
		'{16'h0000, 16'hC800, 16'h0, 8'd8, 8'd8},
		'{16'h0000, 16'hCC00, 16'h0, 8'd16, 8'd0},
		'{16'h0200, 16'hC000, 16'h0, 8'd8, 8'd32},
		'{16'h0100, 16'hC000, 16'h0, 8'd8, 8'd32}};
	// ----------------------------------------
	// design and far side
	// ----------------------------------------
	hspw_gen u_hspw_gen (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .currentLimit(currentLimit),
		.gpioHigh(gpioHigh), .gpioLow(gpioLow), .irq(irq),
		.highSideOutput(highSideOutput), .lowSideOutput(lowSideOutput));
	hspw_gate_driver u_hspw_gate_driver (.clk(clk),
		.highSideOutput(highSideOutput), .lowSideOutput(lowSideOutput),
		.tripReq(tripReq), .clrStats(clrStats), .currentLimit(currentLimit),
		.shootCount(shootCount), .longestOn(longestOn));
	always #5 clk = ~clk;
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	// one single ahb-lite word transfer; waits are bounded
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 99);
		if (hreadyout !== 1'b1) mismatches++;
		r = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, rd);
	endtask : wr
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// high and low cycles over 40 clocks, a whole multiple of every period
	task automatic count40();
		nh = 0;
		nl = 0;
		repeat (40) begin
			@(posedge clk);
			nh += int'(highSideOutput === 1'b1);
			nl += int'(lowSideOutput === 1'b1);
		end
	endtask : count40
	// poll the running count until it lies in a window
	task automatic wait_count(input int lo, input int hi);
		int k;
		k = 0;
		do begin bus(1'b0, ADDR_STATE, 32'h0, rd); k++; end
		while ((rd < lo || rd > hi) && k < 400);
		if (rd < lo || rd > hi) mismatches++;
	endtask : wait_count
	// cycles until the high leg (and the low one too, if asked) is off
	task automatic wait_off(input logic both);
		n = 0;
		while ((highSideOutput === 1'b1 || (both && lowSideOutput === 1'b1))
			&& n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) mismatches++;
	endtask : wait_off
	task automatic finish_test();
		$display("checks_done %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : finish_test
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		chk({highSideOutput, lowSideOutput, irq}, 3'b000);
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 32'h0, rd);
			chk(rd, rows[i].e);
			chk({hreadyout, hresp}, 2'b10);
		end
		// gpio owns the pins after reset
		gpioHigh <= 1'b1;
		repeat (3) @(posedge clk);
		chk({highSideOutput, lowSideOutput}, 2'b10);
		gpioHigh <= 1'b0;
		gpioLow <= 1'b1;
		repeat (3) @(posedge clk);
		chk({highSideOutput, lowSideOutput}, 2'b01);
		// override set before enable, with a divided pwm clock
		wr(ADDR_CLOCK_DIV, 32'h2);
		wr(ADDR_GEN_IO_CTRL, 32'h0380);
		wr(ADDR_GLOBAL_CTRL, 32'h8000);
		wr(ADDR_GEN_IO_CTRL, 32'hC380);
		repeat (3) @(posedge clk);
		chk({highSideOutput, lowSideOutput}, 2'b10);
		repeat (60) @(posedge clk);
		chk({highSideOutput, lowSideOutput}, 2'b10);
		wr(ADDR_CLOCK_DIV, 32'h0);
		wr(ADDR_GEN_DUTY, 32'h4);
		wr(ADDR_MASTER_DUTY, 32'h2);
		foreach (waves[i]) begin
			wr(ADDR_GEN_CTRL, 32'(waves[i].c));
			wr(ADDR_GEN_IO_CTRL, 32'(waves[i].io));
			wr(ADDR_DEAD_TIME, 32'(waves[i].dt));
			repeat (40) @(posedge clk);
			count40();
			chk(32'(nh), 32'(waves[i].eh));
			chk(32'(nl), 32'(waves[i].el));
		end
		// duty to zero in redundant and push-pull leaves no boundary pulse
		wr(ADDR_GEN_CTRL, 32'h0);
		for (int m = 1; m < 3; m++) begin
			wr(ADDR_GEN_IO_CTRL, 32'hC000 | (m << MODE_LSB));
			wr(ADDR_GEN_DUTY, 32'h4);
			repeat (40) @(posedge clk);
			wr(ADDR_GEN_DUTY, 32'h0);
			wait_off(1'b1);
			count40();
			chk(32'(nh + nl), 32'h0);
		end
		// back-to-back duty writes, some land on the rollover
		wr(ADDR_GEN_IO_CTRL, 32'hC000);
		clrStats <= 1'b1;
		@(posedge clk);
		clrStats <= 1'b0;
		for (int k = 0; k < 30; k++) wr(ADDR_GEN_DUTY, k[0] ? 32'h6 : 32'h3);
		chk(32'(longestOn <= 6), 32'h1);
		// current limit forces the low level, interrupt masked then unmasked
		wr(ADDR_IRQ_MASK, 32'h0);
		wr(ADDR_LIMIT_CTRL, 32'h5);
		tripReq <= 1'b1;
		repeat (8) @(posedge clk);
		chk({highSideOutput, lowSideOutput, irq}, 3'b010);
		wr(ADDR_IRQ_MASK, 32'h2);
		#1;
		chk(irq, 1'b1);
		bus(1'b0, ADDR_IRQ_STATUS, 32'h0, rd);
		chk(rd[IRQ_LIMIT_BIT], 1'b1);
		@(posedge clk);
		#1;
		chk(irq, 1'b0);
		wr(ADDR_GEN_IO_CTRL, 32'hC400);
		repeat (3) @(posedge clk);
		chk({highSideOutput, lowSideOutput}, 2'b01);
		wr(ADDR_GEN_IO_CTRL, 32'hC000);
		tripReq <= 1'b0;
		wr(ADDR_LIMIT_CTRL, 32'h0);
		// buffered against immediate duty update in a long period
		wr(ADDR_MASTER_PERIOD, 32'h63);
		wr(ADDR_DEAD_TIME, 32'h2);
		for (int u = 0; u < 2; u++) begin
			wr(ADDR_GEN_DUTY, 32'd50);
			wr(ADDR_GEN_CTRL, 32'(u));
			repeat (220) @(posedge clk);
			wait_count(10, 25);
			wr(ADDR_GEN_DUTY, 32'd80);
			wait_off(1'b0);
			chk(32'(n >= 45), 32'(u));
		end
		// immediate write below the running count switches at once
		wait_count(40, 60);
		wr(ADDR_GEN_DUTY, 32'd20);
		repeat (4) @(posedge clk);
		chk({highSideOutput, lowSideOutput}, 2'b00);
		repeat (3) @(posedge clk);
		chk(lowSideOutput, 1'b1);
		chk(32'(shootCount), 32'h0);
		finish_test();
	end
	// watchdog well beyond the expected run length
	initial begin
		#1000000;
		mismatches++;
		finish_test();
	end
endmodule : testbench
